//--- rtl/trp_defs.svh
// Constants of the timing reference and pulse generator: offsets, fields, resets, timings.
`ifndef TRP_DEFS_SVH
`define TRP_DEFS_SVH

// ****************************************************************
// Register byte addresses
// ****************************************************************
`define TRP_A_CTRL     8'h00
`define TRP_A_PERIOD   8'h04
`define TRP_A_OFFSET   8'h08
`define TRP_A_FREQ     8'h0C
`define TRP_A_CMD      8'h10
`define TRP_A_STATUS   8'h14
`define TRP_A_IRQ_STAT 8'h18
`define TRP_A_IRQ_MASK 8'h1C

// ****************************************************************
// Field positions and values
// ****************************************************************
`define TRP_CTRL_PERSIST 0
`define TRP_CTRL_REVERT  1
`define TRP_CTRL_FALL    2
`define TRP_IRQ_PULSE    0
`define TRP_IRQ_LOST     1
`define TRP_IRQ_BAD      2
`define TRP_IRQ_REVERT   3
`define TRP_CMD_FALL     12'h3DE
`define TRP_CMD_RISE     12'h3DF
`define TRP_PERIOD_MIN   7'h01
`define TRP_PERIOD_MAX   7'h78
`define TRP_PERIOD_RST   7'h02
`define TRP_FREQ_MIN     12'h064
`define TRP_FREQ_MAX     12'h834
`define TRP_FREQ_RST     12'h000

// ****************************************************************
// Timing
// ****************************************************************
`define TRP_CLK_NS        100
`define TRP_HALF_SEC_NS   500000000
`define TRP_HALF_SEC_CYC  (`TRP_HALF_SEC_NS / `TRP_CLK_NS)
`define TRP_PULSE_W_NS    1500000
`define TRP_PULSE_W_CYC   (`TRP_PULSE_W_NS / `TRP_CLK_NS)
`define TRP_OFFSET_MAX_NS 500000000
`define TRP_OFFSET_MAX    (`TRP_OFFSET_MAX_NS / `TRP_CLK_NS)

`endif

//--- rtl/trp_pkg.sv
// Types shared by the timing reference and pulse generator.
package trp_pkg;

   typedef enum logic [1:0] {
      TRP_INTERNAL,
      TRP_EXT_WAIT,
      TRP_EXT_LOCKED,
      TRP_EXT_LOST
   } trp_mode_t;

endpackage

//--- rtl/trp_pin_if.sv
// Carrier between the top level and the pin synchroniser.
`timescale 1ns/100ps
interface trp_pin_if #(parameter int W = 2);
   logic [W-1:0] raw;
   logic [W-1:0] level;
   logic [W-1:0] rise;
   logic [W-1:0] fall;
   modport syn (input raw, output level, output rise, output fall);
   modport usr (output raw, input level, input rise, input fall);
endinterface

//--- rtl/trp_sync.sv
// Three-stage pin synchroniser with agreement filter and edge pulses.
`timescale 1ns/100ps
module trp_sync #(
   parameter int W = 2
) (
   input  wire logic sys_clk_i,
   input  wire logic arst_n_i,
   trp_pin_if.syn    pins
);

   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
      logic [W-1:0] s3;
      logic [W-1:0] lvl;
      logic [W-1:0] rise;
      logic [W-1:0] fall;
   } trp_sync_t;

   trp_sync_t st;
   trp_sync_t next_st;
   logic [W-1:0] agree;

   // A level is accepted only once the second and third stages agree.
   always_comb begin
      next_st      = st;
      agree        = ~(st.s2 ^ st.s3);
      next_st.s1   = pins.raw;
      next_st.s2   = st.s1;
      next_st.s3   = st.s2;
      next_st.lvl  = (st.s2 & agree) | (st.lvl & ~agree);
      next_st.rise = next_st.lvl & ~st.lvl;
      next_st.fall = ~next_st.lvl & st.lvl;
   end

   always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign pins.level = st.lvl;
   assign pins.rise  = st.rise;
   assign pins.fall  = st.fall;

endmodule

//--- rtl/trp_top.sv
// Timing reference selection and timing pulse generator with AXI4-Lite registers.
//
// Notes on behaviour
// [R01] Period half second to 60 s, default 1 s.
// [R02] Pulse rests low, high 1-2 ms before fall.
// [R03] Default: rising edge on time boundary.
// [R04] Command 990 aligns falling edge to boundary.
// [R05] Command 991 restores rising edge alignment.
// [R06] Reference frequency 1-21 MHz, 10 kHz steps.
// [R07] Reference frequency resets to zero.
// [R08] Zero frequency selects internal crystal oscillator.
// [R09] Configured reference disables internal oscillator.
// [R10] Persist flag keeps frequency across power cycles.
// [R11] No revert: lock loss alarms, stays external.
// [R12] Revert: lock loss resets to internal oscillator.
// [R13] Locked reference resumes after power returns.
// [R14] Offset up to 500 ms, 100 ns steps.
// [R15] Period counted, restarted at time boundaries.
//
// Added by the designer: the AXI4-Lite register port and the register addresses.
`timescale 1ns/100ps
`include "trp_defs.svh"
module trp_top #(
   parameter int unsigned HALF_SEC_CYC = `TRP_HALF_SEC_CYC,
   parameter int unsigned PULSE_W_CYC  = `TRP_PULSE_W_CYC,
   parameter int unsigned OFFSET_MAX   = `TRP_OFFSET_MAX
) (
   input  wire logic        sys_clk_i,
   input  wire logic        arst_n_i,
   input  wire logic [7:0]  s_axi_awaddr_i,
   input  wire logic        s_axi_awvalid_i,
   output logic             s_axi_awready_o,
   input  wire logic [31:0] s_axi_wdata_i,
   input  wire logic [3:0]  s_axi_wstrb_i,
   input  wire logic        s_axi_wvalid_i,
   output logic             s_axi_wready_o,
   output logic [1:0]       s_axi_bresp_o,
   output logic             s_axi_bvalid_o,
   input  wire logic        s_axi_bready_i,
   input  wire logic [7:0]  s_axi_araddr_i,
   input  wire logic        s_axi_arvalid_i,
   output logic             s_axi_arready_o,
   output logic [31:0]      s_axi_rdata_o,
   output logic [1:0]       s_axi_rresp_o,
   output logic             s_axi_rvalid_o,
   input  wire logic        s_axi_rready_i,
   input  wire logic        time_boundary_i,
   input  wire logic        ref_lock_i,
   input  wire logic [11:0] nv_freq_i,
   input  wire logic        nv_persist_i,
   output logic             timing_pulse_o,
   output logic             osc_en_o,
   output logic             ext_ref_sel_o,
   output logic             alarm_o,
   output logic             irq_o,
   output logic [11:0]      nv_freq_o,
   output logic             nv_persist_o
);

   // ****************************************************************
   // State
   // ****************************************************************
   typedef struct packed {
      logic               awrdy;
      logic               wrdy;
      logic               bvalid;
      logic [1:0]         bresp;
      logic               arrdy;
      logic               rvalid;
      logic [1:0]         rresp;
      logic [31:0]        rdata;
      logic               aw_have;
      logic [7:0]         aw_addr;
      logic               w_have;
      logic [31:0]        w_data;
      logic [3:0]         w_strb;
      logic               booted;
      logic               persist;
      logic               revert;
      logic               fall_align;
      logic [6:0]         period;
      logic signed [24:0] offset;
      logic [11:0]        freq;
      trp_pkg::trp_mode_t mode;
      logic [3:0]         irq_stat;
      logic [3:0]         irq_mask;
      logic               irq;
      logic [31:0]        phase;
      logic [7:0]         hs_acc;
      logic               pulse;
      logic [31:0]        wcnt;
      logic               alarm;
      logic               osc_en;
      logic               ext_sel;
      logic [11:0]        nv_freq;
      logic               nv_persist;
   } trp_state_t;

   trp_state_t st;
   trp_state_t next_st;

   trp_pin_if #(.W(2)) pins ();

   assign pins.raw = {ref_lock_i, time_boundary_i};

   trp_sync #(.W(2)) u_sync (
      .sys_clk_i (sys_clk_i),
      .arst_n_i  (arst_n_i),
      .pins      (pins)
   );

   logic               aw_now;
   logic               w_now;
   logic               wr_fire;
   logic [7:0]         wr_addr;
   logic [31:0]        wv;
   logic [3:0]         ev;
   logic signed [31:0] rp;
   logic [31:0]        per_cyc;
   logic [7:0]         acc;
   logic               restart;
   logic               lock_lost;

   // Byte lanes not strobed keep old_v; every write passes zero as old_v, so they write as zero.
   function automatic logic [31:0] trp_merge(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0]  strb);
      logic [31:0] r;
      r = old_v;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            r[8*i +: 8] = new_v[8*i +: 8];
         end
      end
      return r;
   endfunction

   // ****************************************************************
   // Next state
   // ****************************************************************
   always_comb begin
      next_st   = st;
      ev        = 4'h0;
      wv        = 32'h0000_0000;
      restart   = 1'b0;
      lock_lost = 1'b0;
      acc       = st.hs_acc;

      // Address and data are taken in either order; the write happens in the cycle the second of them is taken.
      aw_now  = st.aw_have | (s_axi_awvalid_i & st.awrdy);
      w_now   = st.w_have | (s_axi_wvalid_i & st.wrdy);
      wr_fire = aw_now & w_now;
      wr_addr = st.aw_have ? st.aw_addr : s_axi_awaddr_i;
      if (s_axi_awvalid_i && st.awrdy) begin
         next_st.aw_have = 1'b1;
         next_st.aw_addr = s_axi_awaddr_i;
      end
      if (s_axi_wvalid_i && st.wrdy) begin
         next_st.w_have = 1'b1;
         next_st.w_data = s_axi_wdata_i;
         next_st.w_strb = s_axi_wstrb_i;
      end
      if (st.bvalid && s_axi_bready_i) begin
         next_st.bvalid = 1'b0;
      end

      if (wr_fire) begin
         next_st.aw_have = 1'b0;
         next_st.w_have  = 1'b0;
         next_st.bvalid  = 1'b1;
         next_st.bresp   = 2'h0;
         wv = st.w_have ? trp_merge(32'h0000_0000, st.w_data, st.w_strb)
                        : trp_merge(32'h0000_0000, s_axi_wdata_i, s_axi_wstrb_i);
         unique case ({wr_addr[7:2], 2'b00})
            `TRP_A_CTRL: begin
               next_st.persist = wv[`TRP_CTRL_PERSIST];
               next_st.revert  = wv[`TRP_CTRL_REVERT];
            end
            `TRP_A_PERIOD: begin
               if (wv[31:0] >= 32'(`TRP_PERIOD_MIN) && wv[31:0] <= 32'(`TRP_PERIOD_MAX)) begin
                  next_st.period = wv[6:0];                               // see [R01]
               end else begin
                  ev[`TRP_IRQ_BAD] = 1'b1;
               end
            end
            `TRP_A_OFFSET: begin
               if ($signed(wv) <= $signed(OFFSET_MAX) &&
                   $signed(wv) >= -$signed(OFFSET_MAX)) begin
                  next_st.offset = wv[24:0];                              // see [R14]
               end else begin
                  ev[`TRP_IRQ_BAD] = 1'b1;
               end
            end
            `TRP_A_FREQ: begin
               if (wv == 32'h0000_0000) begin
                  next_st.freq = 12'h000;                                 // see [R08]
                  next_st.mode = trp_pkg::TRP_INTERNAL;
               end else if (wv <= 32'(`TRP_FREQ_MAX) && wv >= 32'(`TRP_FREQ_MIN)) begin
                  next_st.freq = wv[11:0];                                // see [R06]
                  next_st.mode = trp_pkg::TRP_EXT_WAIT;
               end else begin
                  ev[`TRP_IRQ_BAD] = 1'b1;
               end
            end
            `TRP_A_CMD: begin
               if (wv[11:0] == `TRP_CMD_FALL && wv[31:12] == 20'h00000) begin
                  next_st.fall_align = 1'b1;                              // see [R04]
               end else if (wv[11:0] == `TRP_CMD_RISE && wv[31:12] == 20'h00000) begin
                  next_st.fall_align = 1'b0;                              // see [R05]
               end else begin
                  ev[`TRP_IRQ_BAD] = 1'b1;
               end
            end
            `TRP_A_IRQ_STAT: begin
               next_st.irq_stat = st.irq_stat & ~wv[3:0];
            end
            `TRP_A_IRQ_MASK: begin
               next_st.irq_mask = wv[3:0];
            end
            `TRP_A_STATUS: begin
            end
            default: begin
               next_st.bresp = 2'h2;
            end
         endcase
      end
      next_st.awrdy = ~next_st.aw_have & ~next_st.bvalid;
      next_st.wrdy  = ~next_st.w_have & ~next_st.bvalid;

      // Reads answer one cycle after the address is taken.
      if (st.rvalid && s_axi_rready_i) begin
         next_st.rvalid = 1'b0;
      end
      if (s_axi_arvalid_i && st.arrdy) begin
         next_st.rvalid = 1'b1;
         next_st.rresp  = 2'h0;
         next_st.rdata  = 32'h0000_0000;
         unique case ({s_axi_araddr_i[7:2], 2'b00})
            `TRP_A_CTRL: begin
               next_st.rdata[`TRP_CTRL_PERSIST] = st.persist;
               next_st.rdata[`TRP_CTRL_REVERT]  = st.revert;
               next_st.rdata[`TRP_CTRL_FALL]    = st.fall_align;
            end
            `TRP_A_PERIOD:   next_st.rdata[6:0]  = st.period;
            `TRP_A_OFFSET:   next_st.rdata       = 32'($signed(st.offset));
            `TRP_A_FREQ:     next_st.rdata[11:0] = st.freq;
            `TRP_A_STATUS:   next_st.rdata[2:0]  = {st.alarm, pins.level[1], st.ext_sel};
            `TRP_A_IRQ_STAT: next_st.rdata[3:0]  = st.irq_stat;
            `TRP_A_IRQ_MASK: next_st.rdata[3:0]  = st.irq_mask;
            `TRP_A_CMD:      next_st.rdata       = 32'h0000_0000;
            default:         next_st.rresp       = 2'h2;
         endcase
      end
      next_st.arrdy = ~next_st.rvalid;

      // The retained store is caught once, on the first edge after reset release.
      if (!st.booted) begin
         next_st.booted = 1'b1;
         if (nv_persist_i && nv_freq_i >= `TRP_FREQ_MIN && nv_freq_i <= `TRP_FREQ_MAX) begin
            next_st.persist = 1'b1;                                       // see [R10]
            next_st.freq    = nv_freq_i;                                  // see [R13]
            next_st.mode    = trp_pkg::TRP_EXT_WAIT;
         end
      end

      // ****************************************************************
      // Reference selection and lock supervision
      // ****************************************************************
      unique case (st.mode)
         trp_pkg::TRP_INTERNAL: begin
         end
         trp_pkg::TRP_EXT_WAIT: begin
            if (pins.level[1] && next_st.mode == trp_pkg::TRP_EXT_WAIT) begin
               next_st.mode = trp_pkg::TRP_EXT_LOCKED;
            end
         end
         trp_pkg::TRP_EXT_LOCKED: begin
            if (pins.fall[1] && next_st.mode == trp_pkg::TRP_EXT_LOCKED) begin
               lock_lost = 1'b1;
               if (st.revert) begin
                  next_st.freq = 12'h000;                                 // see [R12]
                  next_st.mode = trp_pkg::TRP_INTERNAL;
                  ev[`TRP_IRQ_REVERT] = 1'b1;
                  restart = 1'b1;
               end else begin
                  next_st.mode = trp_pkg::TRP_EXT_LOST;                   // see [R11]
                  ev[`TRP_IRQ_LOST] = 1'b1;
               end
            end
         end
         trp_pkg::TRP_EXT_LOST: begin
            if (pins.level[1] && next_st.mode == trp_pkg::TRP_EXT_LOST) begin
               next_st.mode = trp_pkg::TRP_EXT_LOCKED;
            end
         end
      endcase
      next_st.alarm   = (next_st.mode == trp_pkg::TRP_EXT_LOST);
      next_st.osc_en  = (next_st.freq == 12'h000);                        // see [R09]
      next_st.ext_sel = (next_st.freq != 12'h000);
      next_st.nv_persist = next_st.persist;
      next_st.nv_freq    = next_st.persist ? next_st.freq : 12'h000;      // see [R10]

      // ****************************************************************
      // Pulse timing
      // ****************************************************************
      per_cyc = 32'(st.period) * 32'(HALF_SEC_CYC);
      if (pins.rise[0]) begin
         acc = 8'((16'(st.hs_acc) + 16'h0002) % 16'(st.period));
         restart = restart | (acc == 8'h00);                              // see [R15]
         next_st.hs_acc = acc;
      end
      rp = -32'($signed(st.offset));                                      // see [R14]
      if (st.fall_align) begin
         rp = rp - $signed(32'(PULSE_W_CYC));                             // see [R04]
      end
      if (rp < 0) begin
         rp = rp + $signed(per_cyc);
      end
      if (rp < 0) begin
         rp = rp + $signed(per_cyc);
      end
      if (rp >= $signed(per_cyc)) begin
         rp = rp - $signed(per_cyc);
      end
      if (restart) begin
         next_st.phase = 32'h0000_0000;
      end else if (st.phase + 32'h0000_0001 >= per_cyc) begin
         next_st.phase = 32'h0000_0000;
      end else begin
         next_st.phase = st.phase + 32'h0000_0001;
      end

      // The pulse is a fixed 1.5 ms high interval ending at its falling edge.
      if (st.pulse) begin
         if (st.wcnt == 32'h0000_0001) begin
            next_st.pulse = 1'b0;                                         // see [R02]
         end
         next_st.wcnt = st.wcnt - 32'h0000_0001;
      end else if (st.phase == $unsigned(rp)) begin
         next_st.pulse = 1'b1;                                            // see [R03]
         next_st.wcnt  = 32'(PULSE_W_CYC);
         ev[`TRP_IRQ_PULSE] = 1'b1;
      end

      // A set arriving in the cycle of its clear wins.
      next_st.irq_stat = next_st.irq_stat | ev;
      next_st.irq      = |(next_st.irq_stat & next_st.irq_mask);
   end

   always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         st            <= '0;
         st.awrdy      <= 1'b1;
         st.wrdy       <= 1'b1;
         st.arrdy      <= 1'b1;
         st.period     <= `TRP_PERIOD_RST;                                // see [R01]
         st.freq       <= `TRP_FREQ_RST;                                  // see [R07]
         st.mode       <= trp_pkg::TRP_INTERNAL;
         st.osc_en     <= 1'b1;
      end else begin
         st <= next_st;
      end
   end

   assign s_axi_awready_o = st.awrdy;
   assign s_axi_wready_o  = st.wrdy;
   assign s_axi_bvalid_o  = st.bvalid;
   assign s_axi_bresp_o   = st.bresp;
   assign s_axi_arready_o = st.arrdy;
   assign s_axi_rvalid_o  = st.rvalid;
   assign s_axi_rresp_o   = st.rresp;
   assign s_axi_rdata_o   = st.rdata;
   assign timing_pulse_o  = st.pulse;
   assign osc_en_o        = st.osc_en;
   assign ext_ref_sel_o   = st.ext_sel;
   assign alarm_o         = st.alarm;
   assign irq_o           = st.irq;
   assign nv_freq_o       = st.nv_freq;
   assign nv_persist_o    = st.nv_persist;

   // ****************************************************************
   // Checks
   // ****************************************************************
   logic [31:0] hi_cnt;

   always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         hi_cnt <= 32'h0000_0000;
      end else begin
         hi_cnt <= timing_pulse_o ? hi_cnt + 32'h0000_0001 : 32'h0000_0000;
      end
   end

   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (!arst_n_i);

   pulse_width_a: assert property ($fell(timing_pulse_o) |-> hi_cnt == PULSE_W_CYC) // see [R02]
      else $error("Timing pulse high time wrong.");
   period_range_a: assert property (st.period >= `TRP_PERIOD_MIN &&                 // see [R01]
                                    st.period <= `TRP_PERIOD_MAX)
      else $error("Pulse period out of range.");
   osc_off_a: assert property ((st.freq != 12'h000) == !osc_en_o)                    // see [R09]
      else $error("Internal oscillator enable disagrees with reference setting.");
   zero_freq_a: assert property (wr_fire && {wr_addr[7:2], 2'b00} == `TRP_A_FREQ &&  // see [R08]
                                 wv == 32'h0000_0000 && !lock_lost |=> osc_en_o && !ext_ref_sel_o)
      else $error("Zero frequency did not select the internal oscillator.");
   fall_cmd_a: assert property (wr_fire && {wr_addr[7:2], 2'b00} == `TRP_A_CMD &&    // see [R04]
                                wv == 32'(`TRP_CMD_FALL) |=> st.fall_align)
      else $error("Falling edge alignment command ignored.");
   rise_cmd_a: assert property (wr_fire && {wr_addr[7:2], 2'b00} == `TRP_A_CMD &&    // see [R05]
                                wv == 32'(`TRP_CMD_RISE) |=> !st.fall_align)
      else $error("Rising edge alignment command ignored.");
   revert_lost_a: assert property (lock_lost && st.revert |=> osc_en_o && !ext_ref_sel_o && !alarm_o) // see [R12]
      else $error("Lock loss with revert did not return to internal oscillator.");
   stay_ext_a: assert property (lock_lost && !st.revert |=> alarm_o && ext_ref_sel_o) // see [R11]
      else $error("Lock loss without revert left the external source.");
   rise_point_a: assert property ($rose(timing_pulse_o) |-> $past(st.phase) == $past($unsigned(rp))) // see [R03]
      else $error("Timing pulse started away from its alignment point.");
   offset_range_a: assert property ($signed(st.offset) <= $signed(OFFSET_MAX))      // see [R14]
      else $error("Offset beyond limit.");

   pulse_seen_c: cover property ($rose(timing_pulse_o));
   lost_seen_c: cover property (lock_lost && !st.revert);
   revert_seen_c: cover property (lock_lost && st.revert);
   fall_mode_c: cover property (st.fall_align && $rose(timing_pulse_o));

endmodule

//--- bench/trp_ref_src.sv
// Far-side model: system time boundary source and external reference lock.
`timescale 1ns/100ps
module trp_ref_src #(
   parameter int PER = 200
) (
   input  wire logic clk_i,
   input  wire logic rst_n_i,
   input  wire logic lock_want_i,
   output logic      boundary_o,
   output logic      ref_lock_o
);
   int         n;
   logic [2:0] lk;
   always @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         n  <= 0;
         lk <= 3'h0;
      end else begin
         n  <= (n == PER - 1) ? 0 : n + 1;
         lk <= {lk[1:0], lock_want_i};
      end
   end
   // Lock follows the request late, as a real loop settles slowly.
   assign boundary_o = (n < 4);
   assign ref_lock_o = lk[2];
endmodule

//--- bench/tb_top.sv
// Self-checking bench of the timing pulse generator and reference selection.
`timescale 1ns/100ps
`include "trp_defs.svh"
module tb_top;
   logic        clk, arst_n, awv, wv, bre, arv, rre, lock_want, nv_p, bnd_q, pul_q;
   logic [7:0]  awa, ara;
   logic [31:0] wd, rd, seed;
   logic [11:0] nv_f;
   logic [1:0]  resp;
   wire logic   awr, wr, bv, arr, rv, pulse, osc, ext, alarm, irq, nvp_o, bnd, lock;
   wire logic [1:0]  bresp, rresp;
   wire logic [31:0] rdata;
   wire logic [11:0] nvf_o;
   int          errors = 0, n_compared = 0, cnt = 0, t_rise = 0, t_fall = 0, ticks = 0;
   int          d0, exp_freq;
   trp_top #(.HALF_SEC_CYC(100), .PULSE_W_CYC(5), .OFFSET_MAX(40)) dut_u (
      .sys_clk_i(clk), .arst_n_i(arst_n), .s_axi_awaddr_i(awa), .s_axi_awvalid_i(awv),
      .s_axi_awready_o(awr), .s_axi_wdata_i(wd), .s_axi_wstrb_i(4'hF), .s_axi_wvalid_i(wv),
      .s_axi_wready_o(wr), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bv), .s_axi_bready_i(bre),
      .s_axi_araddr_i(ara), .s_axi_arvalid_i(arv), .s_axi_arready_o(arr),
      .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rv),
      .s_axi_rready_i(rre), .time_boundary_i(bnd), .ref_lock_i(lock), .nv_freq_i(nv_f),
      .nv_persist_i(nv_p), .timing_pulse_o(pulse), .osc_en_o(osc), .ext_ref_sel_o(ext),
      .alarm_o(alarm), .irq_o(irq), .nv_freq_o(nvf_o), .nv_persist_o(nvp_o));
   trp_ref_src #(.PER(200)) src_u (.clk_i(clk), .rst_n_i(arst_n), .lock_want_i(lock_want),
      .boundary_o(bnd), .ref_lock_o(lock));
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   task automatic test_done();
      if (errors == 0 && n_compared > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      n_compared++;
      if (s !== e) begin
         errors++;
         $display("[FAIL] %0t seen %h expected %h", $time, s, e);
      end
   endtask
   // Times of pulse edges are counted from the boundary seen on the pin.
   always @(posedge clk) begin
      bnd_q <= bnd;
      pul_q <= pulse;
      cnt   <= (bnd && !bnd_q) ? 0 : cnt + 1;
      if (pulse && !pul_q) t_rise <= cnt;
      if (!pulse && pul_q) t_fall <= cnt;
      ticks <= ticks + 1;
      if (ticks == 60000) begin
         errors++;
         test_done();
      end
   end
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], 1'b0} ^ (s[31] ? 32'h0400_0007 : 32'h0000_0000);
   endfunction
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      awa <= a;
      wd  <= d;
      awv <= 1'b1;
      wv  <= 1'b1;
      bre <= 1'b1;
      do begin
         @(posedge clk);
         if (awr) awv <= 1'b0;
         if (wr) wv <= 1'b0;
      end while (!bv);
      resp = bresp;
      bre <= 1'b0;
   endtask
   task automatic axi_rd(input logic [7:0] a);
      @(posedge clk);
      ara <= a;
      arv <= 1'b1;
      rre <= 1'b1;
      do begin
         @(posedge clk);
         if (arr) arv <= 1'b0;
      end while (!rv);
      rd   = rdata;
      resp = rresp;
      rre <= 1'b0;
   endtask
   task automatic wf(input int d);
      axi_wr(`TRP_A_FREQ, d);
      if (d == 0 || (d >= 100 && d <= 2100)) exp_freq = d;
      axi_rd(`TRP_A_FREQ);
      chk(rd, exp_freq);
      chk(osc, exp_freq == 0);
      chk(ext, exp_freq != 0);
   endtask
   initial begin
      {arst_n, awv, wv, bre, arv, rre, lock_want, nv_p} = 8'h00;
      awa      = 8'h00;
      ara      = 8'h00;
      wd       = 32'h0000_0000;
      nv_f     = 12'h000;
      seed     = 32'hF46D;
      exp_freq = 0;
      repeat (6) @(posedge clk);
      arst_n <= 1'b1;
      axi_rd(`TRP_A_PERIOD);
      chk(rd, 2);
      axi_rd(`TRP_A_FREQ);
      chk(rd, 0);
      chk(osc, 1);
      axi_wr(8'h40, 1);
      chk(resp, 2'h2);
      axi_rd(8'h40);
      chk(resp, 2'h2);
      chk(rd, 0);
      axi_wr(`TRP_A_PERIOD, 121);
      axi_rd(`TRP_A_PERIOD);
      chk(rd, 2);
      axi_wr(`TRP_A_PERIOD, 120);
      axi_rd(`TRP_A_PERIOD);
      chk(rd, 120);
      axi_wr(`TRP_A_PERIOD, 2);
      repeat (450) @(posedge clk);
      chk(t_fall - t_rise, 5);
      d0 = t_rise;
      axi_wr(`TRP_A_OFFSET, 10);
      repeat (450) @(posedge clk);
      // A positive offset advances the pulse; edge times wrap at the 200-cycle boundary.
      chk(t_rise, d0 + 190);
      axi_wr(`TRP_A_OFFSET, 0);
      axi_wr(`TRP_A_CMD, 990);
      repeat (450) @(posedge clk);
      chk(t_fall, d0);
      axi_wr(`TRP_A_CMD, 991);
      repeat (450) @(posedge clk);
      chk(t_rise, d0);
      axi_wr(`TRP_A_IRQ_MASK, 4);
      wf(99);
      repeat (3) @(posedge clk);
      chk(irq, 1);
      axi_wr(`TRP_A_IRQ_STAT, 4);
      repeat (3) @(posedge clk);
      chk(irq, 0);
      for (int i = 0; i < 8; i++) begin
         seed = lfsr(seed);
         wf((i == 3) ? 0 : seed % 2200);
      end
      wf(100);
      lock_want <= 1'b1;
      repeat (30) @(posedge clk);
      lock_want <= 1'b0;
      repeat (30) @(posedge clk);
      chk(alarm, 1);
      chk(ext, 1);
      axi_rd(`TRP_A_STATUS);
      chk(rd, 5);
      axi_wr(`TRP_A_CTRL, 2);
      wf(100);
      lock_want <= 1'b1;
      repeat (30) @(posedge clk);
      lock_want <= 1'b0;
      repeat (30) @(posedge clk);
      axi_rd(`TRP_A_FREQ);
      chk(rd, 0);
      chk(osc, 1);
      axi_wr(`TRP_A_CTRL, 1);
      wf(150);
      chk(nvf_o, 150);
      chk(nvp_o, 1);
      lock_want <= 1'b1;
      repeat (30) @(posedge clk);
      nv_f   <= nvf_o;
      nv_p   <= 1'b1;
      arst_n <= 1'b0;
      repeat (6) @(posedge clk);
      arst_n <= 1'b1;
      repeat (3) @(posedge clk);
      chk(ext, 1);
      axi_rd(`TRP_A_FREQ);
      chk(rd, 150);
      repeat (30) @(posedge clk);
      axi_rd(`TRP_A_STATUS);
      chk(rd, 3);
      test_done();
   end
endmodule
